/* logic/iexs_map.vh */
// Constants for the interrupt and exception sequencer.
// Assumes inclusion by bare name from logic/ and testbench/.
`ifndef IEXS_MAP_VH
`define IEXS_MAP_VH

// -------------------------------------------------------------
// Vector numbers
// -------------------------------------------------------------
`define IEXS_VEC_NONE   8'h00
`define IEXS_VEC_DEBUG  8'h01
`define IEXS_VEC_NMI    8'h02
`define IEXS_VEC_BKPT   8'h03
`define IEXS_VEC_INVOP  8'h06
`define IEXS_VEC_NODEV  8'h07
`define IEXS_VEC_DBLF   8'h08
`define IEXS_VEC_INVTSS 8'h0a
`define IEXS_VEC_SEGNP  8'h0b
`define IEXS_VEC_GP     8'h0d
`define IEXS_VEC_PF     8'h0e
`define IEXS_VEC_CPERR  8'h10

// -------------------------------------------------------------
// Flag word and machine status word
// -------------------------------------------------------------
`define IEXS_FLAG_IF    9
`define IEXS_FLAG_VM    17
`define IEXS_FLAG_RST   32'h00000002
`define IEXS_FLAG_MASK  32'h0003ffff
`define IEXS_MSW_PE     0
`define IEXS_MSW_MP     1
`define IEXS_MSW_EM     2
`define IEXS_MSW_TS     3
`define IEXS_MSW_RST    32'h00000010

// -------------------------------------------------------------
// Architectural reset values
// -------------------------------------------------------------
`define IEXS_IP_RST     32'h0000fff0
`define IEXS_CS_RST     32'h0000f000
`define IEXS_CSBASE_RST 32'hffff0000
`define IEXS_LIMIT_RST  32'h0000ffff
`define IEXS_ZERO       32'h00000000
`define IEXS_ONE        32'h00000001

// -------------------------------------------------------------
// Reset-to-fetch latency in double-rate clock periods
// -------------------------------------------------------------
`define IEXS_FETCH_MIN_DOUBLE_RATE_CLOCK 350
`define IEXS_FETCH_MAX_DOUBLE_RATE_CLOCK 450
`define IEXS_DOUBLE_RATE_CLOCK_NS        5
`define IEXS_MCLK_NS        5

// -------------------------------------------------------------
// Register word offsets
// -------------------------------------------------------------
`define IEXS_REG_FLAGS  4'h0
`define IEXS_REG_MSW    4'h1
`define IEXS_REG_IP     4'h2
`define IEXS_REG_CS     4'h3
`define IEXS_REG_CSBASE 4'h4
`define IEXS_REG_LIMIT  4'h5
`define IEXS_REG_DSES   4'h6
`define IEXS_REG_ACC    4'h7
`define IEXS_REG_DEXT   4'h8
`define IEXS_REG_STAT   4'h9
`define IEXS_REG_VEC    4'ha

`endif

/* logic/iexs_sequencer.v */
// Interrupt and exception sequencer of the processor core.
// Assumes the core pulses its event inputs on mclk_in; only the
// request pins and the coprocessor error pin are asynchronous.

`timescale 1ns/1ps
`include "iexs_map.vh"

module iexs_sequencer #(
  parameter [31:0] DEXT_ID     = 32'h00005a5a,  // Arbitrary identifier value.
  parameter        FETCH_DELAY = ((`IEXS_FETCH_MIN_DOUBLE_RATE_CLOCK + `IEXS_FETCH_MAX_DOUBLE_RATE_CLOCK) / 2)
                                 * `IEXS_DOUBLE_RATE_CLOCK_NS / `IEXS_MCLK_NS,
  parameter        CNT_W       = 9
) (
  input  wire        mclk_in,
  input  wire        nrst_in,
  // Register port.
  input  wire [3:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output wire [31:0] reg_rdata_out,
  // Asynchronous pins.
  input  wire        nmi_request_in,
  input  wire        maskable_request_in,
  input  wire        coproc_error_in,
  // Core events, same clock.
  input  wire        boundary_in,
  input  wire        step_trap_in,
  input  wire        data_bkpt_in,
  input  wire        exec_bkpt_in,
  input  wire        fetch_seg_fault_in,
  input  wire        fetch_seg_absent_in,
  input  wire        fetch_page_fault_in,
  input  wire        illegal_op_in,
  input  wire        prot_only_op_in,
  input  wire        too_long_in,
  input  wire        priv_viol_in,
  input  wire        wait_op_in,
  input  wire        coprocessor_escape_opcode_in,
  input  wire        mem_seg_fault_in,
  input  wire [7:0]  mem_seg_vec_in,
  input  wire        mem_page_fault_in,
  input  wire        soft_int_in,
  input  wire        soft_int3_in,
  input  wire [7:0]  soft_vec_in,
  input  wire        interrupt_return_instruction_in,
  input  wire [31:0] ret_flags_in,
  input  wire        invoke_fault_in,
  input  wire [7:0]  invoke_vec_in,
  input  wire        handler_entered_in,
  input  wire        far_xfer_in,
  input  wire        selftest_ran_in,
  input  wire        selftest_flaw_in,
  // Results.
  output wire        take_out,
  output wire [7:0]  vector_out,
  output wire        int_ack_out,
  output wire        restart_out,
  output wire        fetch_en_out,
  output wire        cs_hi_addr_zero_out
);

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------

  reg [2:0] nmi_sync_q;
  reg [1:0] maskable_request_sync_q;
  reg [1:0] cperr_sync_q;

  // Two stages before use; the third nmi stage only serves the edge detector.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_sync_q   <= 3'h0;
      maskable_request_sync_q  <= 2'h0;
      cperr_sync_q <= 2'h0;
    end else begin
      nmi_sync_q   <= {nmi_sync_q[1:0], nmi_request_in};
      maskable_request_sync_q  <= {maskable_request_sync_q[0], maskable_request_in};
      cperr_sync_q <= {cperr_sync_q[0], coproc_error_in};
    end
  end

  wire nmi_rise = nmi_sync_q[1] & ~nmi_sync_q[2];
  wire maskable_request_s   = maskable_request_sync_q[1];
  wire cperr_s  = cperr_sync_q[1];

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------

  reg [31:0]      flag_word_q;
  reg [31:0]      machine_status_word_q;
  reg [31:0]      accumulator_register_q;
  reg             init_done_q;
  reg [CNT_W-1:0] fetch_cnt_q;
  reg             run_q;
  reg             hi_zero_q;
  reg             nmi_pend_q;
  reg             nmi_busy_q;
  reg             inv_seg_q;
  reg             inv_pf_q;
  reg             take_q;
  reg             ack_q;
  reg             restart_q;
  reg [7:0]       vector_q;
  reg [31:0]      rdata_q;

  wire ts_f = machine_status_word_q[`IEXS_MSW_TS];
  wire mp_f = machine_status_word_q[`IEXS_MSW_MP];
  wire em_f = machine_status_word_q[`IEXS_MSW_EM];
  wire pe_f = machine_status_word_q[`IEXS_MSW_PE];
  wire vm_f = flag_word_q[`IEXS_FLAG_VM];
  wire if_f = flag_word_q[`IEXS_FLAG_IF];

  // -------------------------------------------------------------
  // Boundary priority
  // -------------------------------------------------------------

  reg       hit;
  reg [7:0] sel_vec;
  reg       sel_fault;
  reg       sel_nmi;
  reg       sel_mask;

  // One winner per boundary; the chain order is the checking order.
  always @* begin
    hit       = 1'b1;
    sel_vec   = `IEXS_VEC_NONE;
    sel_fault = 1'b0;
    sel_nmi   = 1'b0;
    sel_mask  = 1'b0;
    if (step_trap_in | data_bkpt_in) begin
      sel_vec = `IEXS_VEC_DEBUG;
    end else if (nmi_pend_q & ~nmi_busy_q) begin
      sel_vec = `IEXS_VEC_NMI;
      sel_nmi = 1'b1;
    end else if (maskable_request_s & if_f & ~nmi_busy_q) begin
      sel_mask = 1'b1;
    end else if (exec_bkpt_in) begin
      sel_vec   = `IEXS_VEC_DEBUG;
      sel_fault = 1'b1;
    end else if (fetch_seg_fault_in) begin
      sel_vec   = fetch_seg_absent_in ? `IEXS_VEC_SEGNP : `IEXS_VEC_GP;
      sel_fault = 1'b1;
    end else if (fetch_page_fault_in) begin
      sel_vec   = `IEXS_VEC_PF;
      sel_fault = 1'b1;
    end else if (illegal_op_in | (prot_only_op_in & (~pe_f | vm_f))) begin
      sel_vec   = `IEXS_VEC_INVOP;
      sel_fault = 1'b1;
    end else if (too_long_in | priv_viol_in) begin
      sel_vec   = `IEXS_VEC_GP;
      sel_fault = 1'b1;
    end else if (wait_op_in & ts_f & mp_f) begin
      sel_vec   = `IEXS_VEC_NODEV;
      sel_fault = 1'b1;
    end else if (coprocessor_escape_opcode_in & (em_f | ts_f)) begin
      sel_vec   = `IEXS_VEC_NODEV;
      sel_fault = 1'b1;
    end else if ((wait_op_in | coprocessor_escape_opcode_in) & cperr_s) begin
      sel_vec   = `IEXS_VEC_CPERR;
      sel_fault = 1'b1;
    end else if (mem_seg_fault_in) begin
      sel_vec   = mem_seg_vec_in;
      sel_fault = 1'b1;
    end else if (mem_page_fault_in) begin
      sel_vec   = `IEXS_VEC_PF;
      sel_fault = 1'b1;
    end else if (soft_int_in) begin
      sel_vec = soft_int3_in ? `IEXS_VEC_BKPT : soft_vec_in;
    end else begin
      hit = 1'b0;
    end
  end

  // Segment handlers 10 to 13 and the page handler need double-fault watch.
  wire sel_seg   = sel_fault & (sel_vec >= `IEXS_VEC_INVTSS) & (sel_vec <= `IEXS_VEC_GP);
  wire inv_seg_v = (invoke_vec_in >= `IEXS_VEC_INVTSS) & (invoke_vec_in <= `IEXS_VEC_GP);
  wire dbl_fault = invoke_fault_in &
                   (inv_pf_q | (inv_seg_q & (invoke_vec_in != `IEXS_VEC_PF)));
  wire take_bnd  = run_q & boundary_in & hit & ~invoke_fault_in;
  wire take_nmi  = take_bnd & sel_nmi;

  // -------------------------------------------------------------
  // Dispatch
  // -------------------------------------------------------------

  // A fault in handler invocation outranks a boundary event in the same cycle,
  // because the boundary has not really been reached yet.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      take_q    <= 1'b0;
      ack_q     <= 1'b0;
      restart_q <= 1'b0;
      vector_q  <= `IEXS_VEC_NONE;
      inv_seg_q <= 1'b0;
      inv_pf_q  <= 1'b0;
    end else begin
      take_q <= 1'b0;
      ack_q  <= 1'b0;
      if (handler_entered_in) begin
        inv_seg_q <= 1'b0;
        inv_pf_q  <= 1'b0;
      end
      if (run_q & dbl_fault) begin
        take_q    <= 1'b1;
        vector_q  <= `IEXS_VEC_DBLF;
        restart_q <= 1'b0;
        inv_seg_q <= 1'b0;
        inv_pf_q  <= 1'b0;
      end else if (run_q & invoke_fault_in) begin
        take_q    <= 1'b1;
        vector_q  <= invoke_vec_in;
        restart_q <= 1'b1;
        inv_seg_q <= inv_seg_v;
        inv_pf_q  <= (invoke_vec_in == `IEXS_VEC_PF);
      end else if (take_bnd) begin
        take_q    <= 1'b1;
        ack_q     <= sel_mask;
        vector_q  <= sel_vec;
        restart_q <= sel_fault;
        inv_seg_q <= sel_seg;
        inv_pf_q  <= sel_fault & (sel_vec == `IEXS_VEC_PF);
      end
    end
  end

  // -------------------------------------------------------------
  // Non-maskable nesting
  // -------------------------------------------------------------

  // A new edge in the cycle the pending bit is consumed keeps it set.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_pend_q <= 1'b0;
      nmi_busy_q <= 1'b0;
    end else begin
      if (take_nmi)
        nmi_pend_q <= 1'b0;
      if (nmi_rise)
        nmi_pend_q <= 1'b1;
      if (run_q & interrupt_return_instruction_in)
        nmi_busy_q <= 1'b0;
      if (take_nmi)
        nmi_busy_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Flag word and machine status word
  // -------------------------------------------------------------

  wire wr_flags = reg_wr_in & (reg_addr_in == `IEXS_REG_FLAGS);
  wire wr_msw   = reg_wr_in & (reg_addr_in == `IEXS_REG_MSW);

  // Later assignments win: return restore over software, non-maskable entry clear last.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_word_q           <= `IEXS_FLAG_RST;
      machine_status_word_q <= `IEXS_MSW_RST;
    end else begin
      if (wr_flags)
        flag_word_q <= (reg_wdata_in & `IEXS_FLAG_MASK) | `IEXS_FLAG_RST;
      if (run_q & interrupt_return_instruction_in)
        flag_word_q <= (ret_flags_in & `IEXS_FLAG_MASK) | `IEXS_FLAG_RST;
      if (take_nmi)
        flag_word_q[`IEXS_FLAG_IF] <= 1'b0;
      if (wr_msw)
        machine_status_word_q <= reg_wdata_in;
    end
  end

  // -------------------------------------------------------------
  // Reset sequence
  // -------------------------------------------------------------

  // The counter is held at zero by reset, so no edge can start fetching early.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fetch_cnt_q <= {CNT_W{1'b0}};
      run_q       <= 1'b0;
      hi_zero_q   <= 1'b0;
    end else begin
      if (!run_q) begin
        fetch_cnt_q <= fetch_cnt_q + 1'b1;
        if (fetch_cnt_q == FETCH_DELAY[CNT_W-1:0] - 1'b1)
          run_q <= 1'b1;
      end
      if (run_q & far_xfer_in)
        hi_zero_q <= 1'b1;
    end
  end

  // Self-test result is caught one edge after release, never under reset.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_done_q            <= 1'b0;
      accumulator_register_q <= `IEXS_ZERO;
    end else if (!init_done_q) begin
      init_done_q            <= 1'b1;
      accumulator_register_q <= (selftest_ran_in & selftest_flaw_in) ?
                                `IEXS_ONE : `IEXS_ZERO;
    end
  end

  // -------------------------------------------------------------
  // Register read port
  // -------------------------------------------------------------

  reg [31:0] rd_mux;

  // Unmapped offsets read zero.
  always @* begin
    case (reg_addr_in)
      `IEXS_REG_FLAGS:  rd_mux = flag_word_q;
      `IEXS_REG_MSW:    rd_mux = machine_status_word_q;
      `IEXS_REG_IP:     rd_mux = `IEXS_IP_RST;
      `IEXS_REG_CS:     rd_mux = `IEXS_CS_RST;
      `IEXS_REG_CSBASE: rd_mux = `IEXS_CSBASE_RST;
      `IEXS_REG_LIMIT:  rd_mux = `IEXS_LIMIT_RST;
      `IEXS_REG_DSES:   rd_mux = `IEXS_ZERO;
      `IEXS_REG_ACC:    rd_mux = accumulator_register_q;
      `IEXS_REG_DEXT:   rd_mux = DEXT_ID;
      `IEXS_REG_STAT:   rd_mux = {26'h0000000, hi_zero_q, run_q, inv_pf_q,
                                  inv_seg_q, nmi_pend_q, nmi_busy_q};
      `IEXS_REG_VEC:    rd_mux = {24'h000000, vector_q};
      default:          rd_mux = `IEXS_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in)
      rdata_q <= `IEXS_ZERO;
    else
      rdata_q <= reg_rd_in ? rd_mux : `IEXS_ZERO;
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------

  assign reg_rdata_out       = rdata_q;
  assign take_out            = take_q;
  assign vector_out          = vector_q;
  assign int_ack_out         = ack_q;
  assign restart_out         = restart_q;
  assign fetch_en_out        = run_q;
  assign cs_hi_addr_zero_out = hi_zero_q;

endmodule // iexs_sequencer

/* testbench/iexs_sequencer_sva.sv */
// Checker for the interrupt and exception sequencer outputs.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/1ps
module iexs_sequencer_sva #(
  parameter FETCH_DELAY = 400
) (
  input wire       mclk_in,
  input wire       nrst_in,
  input wire       boundary_in,
  input wire       invoke_fault_in,
  input wire [7:0] invoke_vec_in,
  input wire       handler_entered_in,
  input wire       soft_int_in,
  input wire       far_xfer_in,
  input wire       take_out,
  input wire [7:0] vector_out,
  input wire       int_ack_out,
  input wire       restart_out,
  input wire       fetch_en_out,
  input wire       cs_hi_addr_zero_out
);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  reg [15:0] cyc_q;
  reg        seg_q;
  reg        pf_q;
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  // Edges since release and the handler being invoked; seen one cycle late, so stimulus leaves a gap.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_q <= 16'h0000;
      seg_q <= 1'b0;
      pf_q  <= 1'b0;
    end else begin
      if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h0001;
      if (handler_entered_in) begin
        seg_q <= 1'b0;
        pf_q  <= 1'b0;
      end else if (take_out) begin
        seg_q <= seg_q | (vector_out >= 8'h0a && vector_out <= 8'h0d);
        pf_q  <= pf_q | (vector_out == 8'h0e);
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_nmi_no_ack: assert property (take_out && vector_out == 8'h02 |-> !int_ack_out && !restart_out)
    else $error("non-maskable take with acknowledge or restart");
  a_ack_no_vec: assert property (int_ack_out |-> take_out && vector_out == 8'h00)
    else $error("acknowledge without maskable take");
  a_take_cause: assert property (take_out |-> $past(boundary_in | invoke_fault_in))
    else $error("take without boundary or invoke fault");
  a_fetch_early: assert property (fetch_en_out |-> cyc_q >= FETCH_DELAY - 1)
    else $error("fetch enabled too early");
  a_fetch_late: assert property (cyc_q >= FETCH_DELAY + 2 |-> fetch_en_out)
    else $error("fetch enabled too late");
  a_fetch_hold: assert property (fetch_en_out |=> fetch_en_out)
    else $error("fetch enable dropped");
  a_hi_sticky: assert property ($rose(cs_hi_addr_zero_out) |=> cs_hi_addr_zero_out [*8])
    else $error("upper address zeroing not sticky");
  a_hi_set: assert property (far_xfer_in && fetch_en_out |=> ##[0:1] cs_hi_addr_zero_out)
    else $error("upper address zeroing missing after far transfer");
  a_dbl_fault: assert property (invoke_fault_in && fetch_en_out && (pf_q || seg_q && invoke_vec_in != 8'h0e)
    |=> take_out && vector_out == 8'h08 && !restart_out)
    else $error("double fault not raised");
  // A software interrupt n may name a fault vector, yet it is a trap and not restartable.
  a_fault_restart: assert property (take_out && !$past(invoke_fault_in || soft_int_in) &&
    vector_out inside {8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10} |-> restart_out)
    else $error("fault not marked restartable");
  a_bkpt_trap: assert property (take_out && vector_out == 8'h03 |-> !restart_out)
    else $error("breakpoint marked restartable");
endmodule // iexs_sequencer_sva

bind iexs_sequencer iexs_sequencer_sva #(.FETCH_DELAY(FETCH_DELAY)) iexs_sequencer_sva_i (.mclk_in, .nrst_in,
  .boundary_in, .invoke_fault_in, .invoke_vec_in, .handler_entered_in, .soft_int_in, .far_xfer_in, .take_out,
  .vector_out,
  .int_ack_out, .restart_out, .fetch_en_out, .cs_hi_addr_zero_out);

/* testbench/iexs_src_model.sv */
// Model of the external interrupt sources in front of the sequencer.
// Assumes the bench asks for requests through the want inputs.
`timescale 1ns/1ps
module iexs_src_model (
  input  wire mclk_in,
  input  wire nrst_in,
  input  wire nmi_want_in,
  input  wire int_want_in,
  input  wire err_want_in,
  input  wire int_ack_in,
  output reg  nmi_out,
  output reg  int_out,
  output reg  err_out
);
  // ------------------------------------------------------------
  // Request pins
  // ------------------------------------------------------------
  // The maskable request stays up until acknowledged, since it is only sampled at boundaries.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_out <= 1'b0;
      int_out <= 1'b0;
      err_out <= 1'b0;
    end else begin
      nmi_out <= nmi_want_in;
      err_out <= err_want_in;
      if (int_ack_in) int_out <= 1'b0;
      else if (int_want_in) int_out <= 1'b1;
    end
  end
endmodule // iexs_src_model

/* testbench/tb.sv */
// Self-checking bench for the interrupt and exception sequencer.
// Assumes the sequencer, its checker and the source model are compiled first.
`timescale 1ns/1ps
`include "iexs_map.vh"
module tb;
  localparam FD = 8;
  localparam [31:0] DID = 32'h0000c3a5; // Arbitrary identifier value.
  reg mclk_in = 0, nrst_in = 0, wr = 0, rd = 0, bnd = 0, interrupt_return_instruction = 0, ifl = 0, hent = 0, far = 0, flaw = 0;
  reg nmi_w = 0, int_w = 0, err_w = 0;
  reg [3:0] addr = 0;
  reg [31:0] wdata = 0, rfl = 0, rs = 32'hb551;
  reg [15:0] ev = 0, m;
  reg [7:0] mvec = 0, svec = 0, ivec = 0;
  wire nmi, maskable_request, err, take, ack, rst_f, fen, hiz;
  wire [7:0] vec;
  wire [31:0] rdata;
  integer err_count = 0, num_checks = 0, n, k, j;
  reg [9:0] tq[$];
  reg [31:0] rq[$];
  reg [15:0] msk [0:15];
  reg [9:0] vx [0:15];
  reg [31:0] rv [0:8];
  always #2.5 mclk_in = ~mclk_in;
  iexs_sequencer #(.DEXT_ID(DID), .FETCH_DELAY(FD)) iexs_sequencer_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .nmi_request_in(nmi), .maskable_request_in(maskable_request), .coproc_error_in(err), .boundary_in(bnd),
    .step_trap_in(ev[0]), .data_bkpt_in(ev[1]), .exec_bkpt_in(ev[2]), .fetch_seg_fault_in(ev[3]),
    .fetch_seg_absent_in(ev[4]), .fetch_page_fault_in(ev[5]), .illegal_op_in(ev[6]), .prot_only_op_in(ev[7]),
    .too_long_in(ev[8]), .priv_viol_in(ev[9]), .wait_op_in(ev[10]), .coprocessor_escape_opcode_in(ev[11]),
    .mem_seg_fault_in(ev[12]), .mem_seg_vec_in(mvec), .mem_page_fault_in(ev[13]), .soft_int_in(ev[14]),
    .soft_int3_in(ev[15]), .soft_vec_in(svec), .interrupt_return_instruction_in(interrupt_return_instruction), .ret_flags_in(rfl),
    .invoke_fault_in(ifl), .invoke_vec_in(ivec), .handler_entered_in(hent), .far_xfer_in(far),
    .selftest_ran_in(1'b1), .selftest_flaw_in(flaw), .take_out(take), .vector_out(vec), .int_ack_out(ack),
    .restart_out(rst_f), .fetch_en_out(fen), .cs_hi_addr_zero_out(hiz));
  iexs_src_model iexs_src_model_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .nmi_want_in(nmi_w),
    .int_want_in(int_w), .err_want_in(err_w), .int_ack_in(ack), .nmi_out(nmi), .int_out(maskable_request), .err_out(err));
  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] e, input [31:0] s, input [63:0] nm);
    begin
      num_checks = num_checks + 1;
      if (e !== s) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // Takes and read data are matched against the oldest note; a stray take meets an empty queue.
  always @(posedge mclk_in) begin : mon
    reg rdp = 1'b0;
    if (rdp) begin
      if (rq.size() == 0) chk(1, 0, "readq");
      else chk(rq.pop_front(), rdata, "rdata");
    end
    rdp = rd;
    // Before the first reset edge the take flop is still unknown, so only look once out of reset.
    if (nrst_in && take !== 1'b0) begin
      if (tq.size() == 0) chk(0, 1, "takeq");
      else chk(tq.pop_front(), {vec, ack, rst_f}, "take");
    end
  end
  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task cyc(input integer c);
    repeat (c) @(posedge mclk_in);
  endtask
  task rreg(input [3:0] a, input [31:0] e);
    begin
      @(posedge mclk_in); addr <= a; rd <= 1; rq.push_back(e);
      @(posedge mclk_in); rd <= 0;
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk_in); addr <= a; wdata <= d; wr <= 1;
      @(posedge mclk_in); wr <= 0;
    end
  endtask
  task pbnd(input [15:0] e, input [9:0] x, input exp);
    begin
      @(posedge mclk_in); ev <= e; bnd <= 1;
      if (exp) tq.push_back(x);
      @(posedge mclk_in); ev <= 0; bnd <= 0;
      cyc(3);
    end
  endtask
  task pinv(input [7:0] v, input [9:0] x);
    begin
      @(posedge mclk_in); ivec <= v; ifl <= 1; tq.push_back(x);
      @(posedge mclk_in); ifl <= 0;
      cyc(3);
      @(posedge mclk_in); hent <= 1;
      @(posedge mclk_in); hent <= 0;
    end
  endtask
  // Waits for the startup delay under a bound of 40 edges, then checks the edge count.
  task wfetch;
    begin
      n = 0;
      while (fen !== 1'b1 && n < 40) begin
        @(posedge mclk_in);
        n = n + 1;
      end
      chk(1, n >= FD - 1 && n <= FD + 3, "fetchlat");
      if (n == 40) give_verdict;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    give_verdict;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    msk = '{16'h0001, 16'h0002, 16'h0004, 16'h0018, 16'h0008, 16'h0020, 16'h0040, 16'h0080,
            16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'hc000};
    vx = '{10'h004, 10'h004, 10'h005, 10'h02d, 10'h035, 10'h039, 10'h019, 10'h019,
           10'h035, 10'h035, 10'h01d, 10'h01d, 10'h031, 10'h039, 10'h000, 10'h00c};
    rv = '{`IEXS_FLAG_RST, `IEXS_MSW_RST, `IEXS_IP_RST, `IEXS_CS_RST, `IEXS_CSBASE_RST, `IEXS_LIMIT_RST,
           `IEXS_ZERO, `IEXS_ZERO, DID};
    cyc(2);
    nrst_in <= 1;
    wfetch;
    for (k = 0; k < 9; k = k + 1) rreg(k[3:0], rv[k]);
    wreg(4'h2, 32'h0);
    rreg(4'h2, `IEXS_IP_RST);
    rreg(4'hb, 32'h0);
    chk(0, hiz, "hizero");
    // Status word with monitor and switched set; protection off so protected-only opcodes fault.
    wreg(4'h1, 32'h1a);
    mvec <= 8'h0c;
    for (j = 0; j < 2; j = j + 1) begin
      for (k = 0; k < 16; k = k + 1) begin
        rs = xs(rs);
        svec <= rs[7:0];
        // In the second pass the one-byte form rides along and forces vector 3.
        vx[14] = (j == 1) ? 10'h00c : {rs[7:0], 2'b00};
        m = msk[k];
        for (n = k; n < 16 && j == 1; n = n + 1) m = m | msk[n];
        pbnd(m, vx[k], 1);
      end
    end
    wreg(4'h1, 32'h18);
    pbnd(16'h0400, 0, 0);
    pbnd(16'h0800, 10'h01d, 1);
    wreg(4'h1, 32'h14);
    pbnd(16'h0400, 0, 0);
    pbnd(16'h0800, 10'h01d, 1);
    wreg(4'h1, 32'h10);
    err_w <= 1;
    cyc(4);
    pbnd(16'h0400, 10'h041, 1);
    pbnd(16'h0800, 10'h041, 1);
    err_w <= 0;
    // Double faults: page handler, then segment handler with and without a page fault.
    pbnd(16'h2000, 10'h039, 1);
    pinv(8'h0d, 10'h020);
    pbnd(16'h1000, 10'h031, 1);
    pinv(8'h0e, 10'h039);
    pbnd(16'h1000, 10'h031, 1);
    pinv(8'h0b, 10'h020);
    // Maskable request with the enable flag clear is refused.
    int_w <= 1;
    cyc(1);
    int_w <= 0;
    cyc(4);
    pbnd(0, 0, 0);
    wreg(4'h0, 32'h202);
    nmi_w <= 1;
    cyc(10);
    nmi_w <= 0;
    pbnd(0, 10'h008, 1);
    pbnd(0, 0, 0);
    rreg(4'h0, 32'h2);
    nmi_w <= 1;
    cyc(4);
    nmi_w <= 0;
    pbnd(0, 0, 0);
    rfl <= 32'h202;
    @(posedge mclk_in); interrupt_return_instruction <= 1;
    @(posedge mclk_in); interrupt_return_instruction <= 0;
    pbnd(0, 10'h008, 1);
    @(posedge mclk_in); interrupt_return_instruction <= 1;
    @(posedge mclk_in); interrupt_return_instruction <= 0;
    rreg(4'h0, 32'h202);
    pbnd(0, 10'h002, 1);
    @(posedge mclk_in); far <= 1;
    @(posedge mclk_in); far <= 0;
    cyc(2);
    chk(1, hiz, "hizero");
    // Second reset in mid-run with a flawed self-test.
    flaw <= 1;
    nrst_in <= 0;
    cyc(2);
    nrst_in <= 1;
    wfetch;
    rreg(4'h7, `IEXS_ONE);
    chk(0, hiz, "hizero");
    cyc(2);
    chk(0, tq.size() + rq.size(), "pending");
    give_verdict;
  end
endmodule // tb
